// ### sim/ext_irq_props.sv
// port checker for the external pin interrupt unit
`timescale 1ns/1ps
module ext_irq_props
(
	// clock and reset
	input wire logic		ref_clk_in,
	input wire logic		reset_n_in,
	// apb
	input wire logic [7:0]		paddr_in,
	input wire logic		psel_in,
	input wire logic		penable_in,
	input wire logic		pwrite_in,
	input wire logic [31:0]		pwdata_in,
	input wire logic		pready_out,
	input wire logic		pslverr_out,
	// pins and requests
	input wire logic [3:0][7:0]	gpio_pin_out,
	input wire logic [3:0][7:0]	gpio_pin_oe_out,
	input wire logic		sleep_active_in,
	input wire logic [7:0]		ext_irq_req_out,
	input wire logic		pin_change_request_out,
	input wire logic		irq_out,
	input wire logic		wake_out
);
	logic		wr_done;
	logic [8:0]	en_ff;
	logic		gie_ff;

	assign wr_done = psel_in & penable_in & pready_out & pwrite_in;

	// shadow of enable bits seen on the bus
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			en_ff <= 9'h000;
		else if (wr_done && paddr_in == ext_irq_pkg::OFS_IRQ_ENABLE)
			en_ff <= pwdata_in[8:0];
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			gie_ff <= 1'b0;
		else if (wr_done && paddr_in == ext_irq_pkg::OFS_CTRL)
			gie_ff <= pwdata_in[ext_irq_pkg::CTRL_GIE_BIT];
	end

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	chk_apb_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("pready late");
	chk_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("pready longer than one cycle");
	chk_err_with_ready: assert property (pslverr_out |-> pready_out)
		else $error("pslverr without pready");
	chk_dir_by_write: assert property ($changed(gpio_pin_oe_out) |-> $past(wr_done))
		else $error("direction changed without write");
	chk_out_by_write: assert property ($changed(gpio_pin_out) |-> $past(wr_done))
		else $error("output changed without write");
	chk_line_enable: assert property ((ext_irq_req_out & ~en_ff[7:0] & ~$past(en_ff[7:0])) == 8'h00)
		else $error("request on disabled line");
	chk_pc_enable: assert property (pin_change_request_out |-> en_ff[8] || $past(en_ff[8]))
		else $error("pin-change request while disabled");
	chk_global_gate: assert property (irq_out |-> gie_ff || $past(gie_ff))
		else $error("irq without global enable");
	chk_irq_or: assert property (irq_out == (|ext_irq_req_out || pin_change_request_out))
		else $error("irq not the or of requests");
	chk_wake_sleep: assert property (wake_out |-> $past(sleep_active_in))
		else $error("wake while awake");
endmodule

bind external_pin_interrupts ext_irq_props chk_u (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
	.paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
	.pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.gpio_pin_out(gpio_pin_out), .gpio_pin_oe_out(gpio_pin_oe_out),
	.sleep_active_in(sleep_active_in), .ext_irq_req_out(ext_irq_req_out),
	.pin_change_request_out(pin_change_request_out), .irq_out(irq_out), .wake_out(wake_out));

// ### sim/pin_board_model.sv
// board model: pads follow the device drive or the board level
`timescale 1ns/1ps
module pin_board_model
(
	// device drive
	input  wire logic [3:0][7:0]	pin_out_in,
	input  wire logic [3:0][7:0]	pin_oe_in,
	// board levels
	input  wire logic [3:0][7:0]	board_lvl_in,
	// pads seen by the device
	output logic      [3:0][7:0]	pad_out
);
	assign pad_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & board_lvl_in);
endmodule

// ### sim/tb_top.sv
// self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
module tb_top;
	logic			clk, rst_n, psel, pen, pwr, slp, pack, er, woke;
	logic			prdy, perr, pcreq, irq, wake;
	logic [7:0]		paddr, pcl, ack, req;
	logic [31:0]		pwdata, prdata, rd;
	logic [3:0][7:0]	lvl, pin_in, pin_o, pin_oe;
	int			bad_count, n_compared, cyc;

	external_pin_interrupts dut_u (.ref_clk_in(clk), .reset_n_in(rst_n), .paddr_in(paddr),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(prdy), .pslverr_out(perr), .gpio_pin_in(pin_in),
		.gpio_pin_out(pin_o), .gpio_pin_oe_out(pin_oe), .pin_change_lines_in(pcl),
		.sleep_active_in(slp), .ext_irq_ack_in(ack), .pin_change_ack_in(pack),
		.ext_irq_req_out(req), .pin_change_request_out(pcreq), .irq_out(irq), .wake_out(wake));
	pin_board_model board_u (.pin_out_in(pin_o), .pin_oe_in(pin_oe), .board_lvl_in(lvl),
		.pad_out(pin_in));

	// ----
	// helpers
	// ----
	task automatic report_and_stop;
		if (bad_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
			@(posedge clk);
		while (prdy !== 1'b1);
		rd = prdata;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// pulse-free change of one board pad
	task automatic pad(input int p, input int b, input logic v);
		@(posedge clk);
		lvl[p][b] <= v;
	endtask

	function automatic logic [31:0] ctl(input logic [2:0] m);
		return {28'h0, m, 1'b1};
	endfunction

	task automatic clr;
		apb(1'b1, ext_irq_pkg::OFS_IRQ_CLEAR, 32'h1FF);
	endtask

	task automatic status(input logic [31:0] exp);
		apb(1'b0, ext_irq_pkg::OFS_IRQ_STATUS, 32'h0);
		check(rd, exp);
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_regs;
		for (int p = 0; p < 4; p++)
		begin
			apb(1'b0, 8'(p * ext_irq_pkg::OFS_GPIO_STRIDE), 32'h0);
			check(rd, 32'h0);
			apb(1'b0, 8'(p * ext_irq_pkg::OFS_GPIO_STRIDE + 4), 32'h0);
			check(rd, 32'h0);
		end
		apb(1'b1, ext_irq_pkg::OFS_GPIO_DIR, 32'hA5);
		tick(1);
		check(pin_oe[0], 32'hA5);
		apb(1'b0, ext_irq_pkg::OFS_GPIO_PIN, 32'h0);
		check(rd, 32'h5A);
		apb(1'b1, ext_irq_pkg::OFS_GPIO_DIR, 32'h0);
		apb(1'b0, 8'h4C, 32'h0);
		check({er, rd[30:0]}, 32'h80000000);
	endtask

	task automatic t_sense;
		logic [1:0] c;
		for (int i = 1; i < 4; i++)
		begin
			c = 2'(i);
			apb(1'b1, ext_irq_pkg::OFS_SENSE_LOWER, 32'(c));
			clr();
			pad(1, 0, 1'b0);
			tick(4);
			status({31'h0, c != ext_irq_pkg::SENSE_RISE});
			clr();
			status(32'h0);
			pad(1, 0, 1'b1);
			tick(4);
			check(req[0], c != ext_irq_pkg::SENSE_FALL);
			@(posedge clk);
			ack <= 8'h01;
			@(posedge clk);
			ack <= 8'h00;
			tick(3);
			check(req[0], 1'b0);
		end
		apb(1'b1, ext_irq_pkg::OFS_SENSE_LOWER, 32'(ext_irq_pkg::SENSE_LOW));
		pad(1, 0, 1'b0);
		tick(4);
		check({req[0], irq}, 2'b11);
		status(32'h0);
		apb(1'b1, ext_irq_pkg::OFS_CTRL, 32'h0);
		tick(2);
		check(irq, 1'b0);
		apb(1'b1, ext_irq_pkg::OFS_CTRL, ctl(ext_irq_pkg::SLEEP_IDLE));
		pad(1, 0, 1'b1);
		tick(3);
		check(req[0], 1'b0);
	endtask

	task automatic t_out;
		apb(1'b1, ext_irq_pkg::OFS_SENSE_LOWER, 32'(ext_irq_pkg::SENSE_RISE) << 2);
		apb(1'b1, ext_irq_pkg::OFS_GPIO_STRIDE + ext_irq_pkg::OFS_GPIO_DIR, 32'h2);
		clr();
		apb(1'b1, ext_irq_pkg::OFS_GPIO_STRIDE, 32'h2);
		tick(4);
		status(32'h2);
		check(pin_o[1], 32'h2);
		check(req[1], 1'b1);
		apb(1'b1, ext_irq_pkg::OFS_GPIO_STRIDE + ext_irq_pkg::OFS_GPIO_DIR, 32'h0);
		clr();
	endtask

	task automatic t_sleep;
		apb(1'b1, ext_irq_pkg::OFS_SENSE_LOWER, 32'(ext_irq_pkg::SENSE_FALL) << 4);
		apb(1'b1, ext_irq_pkg::OFS_SENSE_UPPER, 32'(ext_irq_pkg::SENSE_FALL));
		clr();
		apb(1'b1, ext_irq_pkg::OFS_CTRL, ctl(ext_irq_pkg::SLEEP_POWER_DOWN));
		woke = 1'b0;
		@(posedge clk);
		slp <= 1'b1;
		// pulses outlast one clock period
		pad(2, 4, 1'b0);
		pad(1, 3, 1'b0);
		pad(1, 2, 1'b0);
		tick(2);
		pad(2, 4, 1'b1);
		pad(1, 3, 1'b1);
		pad(1, 2, 1'b1);
		tick(4);
		check(woke, 1'b1);
		slp <= 1'b0;
		apb(1'b1, ext_irq_pkg::OFS_CTRL, ctl(ext_irq_pkg::SLEEP_IDLE));
		status(32'h4);
		check(req[3], 1'b0);
		clr();
		@(posedge clk);
		slp <= 1'b1;
		pad(2, 4, 1'b0);
		tick(2);
		pad(2, 4, 1'b1);
		tick(4);
		status(32'h10);
		slp <= 1'b0;
		clr();
	endtask

	task automatic t_pc;
		apb(1'b1, ext_irq_pkg::OFS_PC_MASK, 32'h5);
		clr();
		@(posedge clk);
		pcl <= 8'h02;
		tick(4);
		check(pcreq, 1'b0);
		pcl <= 8'h06;
		tick(4);
		check({pcreq, irq}, 2'b11);
		pack <= 1'b1;
		@(posedge clk);
		pack <= 1'b0;
		tick(3);
		check(pcreq, 1'b0);
		apb(1'b1, ext_irq_pkg::OFS_CTRL, ctl(ext_irq_pkg::SLEEP_POWER_DOWN));
		woke = 1'b0;
		@(posedge clk);
		slp <= 1'b1;
		pcl <= 8'h07;
		tick(4);
		check(woke, 1'b1);
		slp <= 1'b0;
		clr();
	endtask

	// ----
	// clock, timeout, sequence
	// ----
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (wake === 1'b1)
			woke = 1'b1;
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			report_and_stop();
		end
	end

	initial
	begin
		{rst_n, psel, pen, pwr, slp, pack, woke} = 7'h00;
		{paddr, pcl, ack, pwdata} = 56'h0;
		lvl = {4{8'hFF}};
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		apb(1'b1, ext_irq_pkg::OFS_IRQ_ENABLE, 32'h1FF);
		apb(1'b1, ext_irq_pkg::OFS_CTRL, ctl(ext_irq_pkg::SLEEP_IDLE));
		t_sense();
		t_out();
		t_sleep();
		t_pc();
		report_and_stop();
	end
endmodule

// ### src/ext_irq_pkg.sv
// shared constants and types for the external pin interrupt unit
package ext_irq_pkg;

	// --------------------------------------------------------------
	// bus and sizes
	// --------------------------------------------------------------
	localparam int DATA_W     = 32;
	localparam int ADDR_W     = 8;
	localparam int PORT_CNT   = 4;
	localparam int LINE_CNT   = 8;

	// --------------------------------------------------------------
	// register byte offsets
	// --------------------------------------------------------------
	localparam logic [7:0] OFS_GPIO_BASE    = 8'h00;
	localparam logic [7:0] OFS_GPIO_STRIDE  = 8'h0C;
	localparam logic [7:0] OFS_GPIO_OUT     = 8'h00;
	localparam logic [7:0] OFS_GPIO_DIR     = 8'h04;
	localparam logic [7:0] OFS_GPIO_PIN     = 8'h08;
	localparam logic [7:0] OFS_SENSE_LOWER  = 8'h30;
	localparam logic [7:0] OFS_SENSE_UPPER  = 8'h34;
	localparam logic [7:0] OFS_PC_MASK      = 8'h38;
	localparam logic [7:0] OFS_CTRL         = 8'h3C;
	localparam logic [7:0] OFS_IRQ_STATUS   = 8'h40;
	localparam logic [7:0] OFS_IRQ_CLEAR    = 8'h44;
	localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h48;

	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int CTRL_GIE_BIT    = 0;
	localparam int CTRL_SLEEP_LSB  = 1;
	localparam int IRQ_PC_BIT      = 8;
	localparam int IRQ_W           = 9;
	localparam int LOWER_LINES     = 4;

	// --------------------------------------------------------------
	// reset values
	// --------------------------------------------------------------
	localparam logic [7:0] GPIO_RESET   = 8'h00;
	localparam logic [7:0] SENSE_RESET  = 8'h00;
	localparam logic [7:0] MASK_RESET   = 8'h00;
	localparam logic [8:0] ENABLE_RESET = 9'h000;

	// --------------------------------------------------------------
	// sense selection codes
	// --------------------------------------------------------------
	localparam logic [1:0] SENSE_LOW  = 2'h0;
	localparam logic [1:0] SENSE_ANY  = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_RISE = 2'h3;

	typedef enum logic [2:0]
	{
		SLEEP_IDLE       = 3'h0,
		SLEEP_ADC_NR     = 3'h1,
		SLEEP_POWER_DOWN = 3'h2,
		SLEEP_POWER_SAVE = 3'h3,
		SLEEP_STANDBY    = 3'h6,
		SLEEP_EXT_STBY   = 3'h7
	} sleep_mode_t;

	typedef struct packed
	{
		logic [7:0] out_val;
		logic [7:0] dir;
	} gpio_regs_t;

endpackage

// ### src/external_pin_interrupts.sv
// external pin interrupt unit with gpio ports c to f, apb register access
// --------------------------------------------------------------
// Overview of operation
// - lines raise interrupts from pin activity even when the pin is an output
// - one pin-change request whenever any enabled pin-change line toggles
// - per-line mask selects which pin-change lines contribute
// - pin-change detection works in every sleep mode
// - each line senses falling, rising edge or low level; two control registers
// - enabled level-sensed line requests as long as the pin stays low
// - edges on lines 7:4 need the running io clock; missed while stopped
// - low levels and edges on lines 3:0 detected in every sleep mode
// - io clock stops in every sleep mode except idle
// - level must last until wake-up ends, else no interrupt is raised
// - lines 3:0 codes: 00 low, 01 any edge, 10 falling, 11 rising
// - lines 7:4 sampled by clock; edges found by comparing samples
// - edge sets flag; cleared by vector entry or writing one
// - flag held cleared while its line is level sensed
// --------------------------------------------------------------
`timescale 1ns/1ps

module external_pin_interrupts
(
	// clock and reset
	input  wire logic                       ref_clk_in,
	input  wire logic                       reset_n_in,
	// apb slave
	input  wire logic [7:0]                 paddr_in,
	input  wire logic                       psel_in,
	input  wire logic                       penable_in,
	input  wire logic                       pwrite_in,
	input  wire logic [31:0]                pwdata_in,
	output logic      [31:0]                prdata_out,
	output logic                            pready_out,
	output logic                            pslverr_out,
	// gpio pins of ports c, d, e, f
	input  wire logic [3:0][7:0]            gpio_pin_in,
	output logic      [3:0][7:0]            gpio_pin_out,
	output logic      [3:0][7:0]            gpio_pin_oe_out,
	// pin-change lines
	input  wire logic [7:0]                 pin_change_lines_in,
	// sleep state of the core
	input  wire logic                       sleep_active_in,
	// cpu interrupt logic
	input  wire logic [7:0]                 ext_irq_ack_in,
	input  wire logic                       pin_change_ack_in,
	output logic      [7:0]                 ext_irq_req_out,
	output logic                            pin_change_request_out,
	output logic                            irq_out,
	output logic                            wake_out
);

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	ext_irq_pkg::gpio_regs_t  gpio_regs_ff [ext_irq_pkg::PORT_CNT];
	logic [7:0]               sense_lower_ff;
	logic [7:0]               sense_upper_ff;
	logic [7:0]               pin_change_mask_ff;
	logic                     gie_ff;
	ext_irq_pkg::sleep_mode_t sleep_mode_ff;
	logic [8:0]               irq_enable_ff;
	logic [7:0]               ext_irq_flags_ff;
	logic                     pc_flag_ff;
	logic [7:0]               ext_prev_ff;
	logic [7:0]               pc_prev_ff;
	logic                     primed_ff;
	logic                     pready_ff;
	logic [31:0]              prdata_ff;
	logic                     pslverr_ff;
	logic [7:0]               ext_req_ff;
	logic                     pc_req_ff;
	logic                     irq_ff;
	logic                     wake_ff;

	logic [7:0]               ext_irq_lines;
	logic [7:0]               edge_hit;
	logic [7:0]               level_mode;
	logic [7:0]               ext_raw_req;
	logic [7:0]               ext_clr;
	logic [7:0]               wake_ev;
	logic                     pc_event;
	logic                     pc_clr;
	logic                     io_clk_run;
	logic                     acc;
	logic                     wr_en;
	logic                     clr_wr;
	logic [31:0]              rd_data;
	logic                     rd_ok;
	logic [7:0]               nxt_ext_req;
	logic                     nxt_pc_req;

	// --------------------------------------------------------------
	// apb handshake
	// --------------------------------------------------------------
	// one wait state: pready rises in the second access cycle
	assign acc    = psel_in & penable_in;
	assign wr_en  = acc & pwrite_in & pready_ff;
	assign clr_wr = wr_en & (paddr_in == ext_irq_pkg::OFS_IRQ_CLEAR);

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff <= acc & ~pready_ff;
			if (acc & ~pready_ff)
			begin
				prdata_ff  <= pwrite_in ? 32'h00000000 : rd_data;
				pslverr_ff <= ~rd_ok;
			end
			else
			begin
				pslverr_ff <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// read decode
	// --------------------------------------------------------------
	always_comb
	begin
		logic [7:0] base;
		base    = ext_irq_pkg::OFS_GPIO_BASE;
		rd_data = 32'h00000000;
		rd_ok   = 1'b0;
		for (int p = 0; p < ext_irq_pkg::PORT_CNT; p++)
		begin
			if (paddr_in == base + ext_irq_pkg::OFS_GPIO_OUT)
			begin
				rd_data[7:0] = gpio_regs_ff[p].out_val;
				rd_ok        = 1'b1;
			end
			if (paddr_in == base + ext_irq_pkg::OFS_GPIO_DIR)
			begin
				rd_data[7:0] = gpio_regs_ff[p].dir;
				rd_ok        = 1'b1;
			end
			if (paddr_in == base + ext_irq_pkg::OFS_GPIO_PIN)
			begin
				rd_data[7:0] = gpio_pin_in[p];
				rd_ok        = 1'b1;
			end
			base = base + ext_irq_pkg::OFS_GPIO_STRIDE;
		end
		case (paddr_in)
			ext_irq_pkg::OFS_SENSE_LOWER:
			begin
				rd_data[7:0] = sense_lower_ff;
				rd_ok        = 1'b1;
			end
			ext_irq_pkg::OFS_SENSE_UPPER:
			begin
				rd_data[7:0] = sense_upper_ff;
				rd_ok        = 1'b1;
			end
			ext_irq_pkg::OFS_PC_MASK:
			begin
				rd_data[7:0] = pin_change_mask_ff;
				rd_ok        = 1'b1;
			end
			ext_irq_pkg::OFS_CTRL:
			begin
				rd_data[ext_irq_pkg::CTRL_GIE_BIT]          = gie_ff;
				rd_data[ext_irq_pkg::CTRL_SLEEP_LSB +: 3]  = sleep_mode_ff;
				rd_ok                                       = 1'b1;
			end
			ext_irq_pkg::OFS_IRQ_STATUS:
			begin
				rd_data[8:0] = {pc_flag_ff, ext_irq_flags_ff};
				rd_ok        = 1'b1;
			end
			ext_irq_pkg::OFS_IRQ_CLEAR:
			begin
				rd_ok = 1'b1;
			end
			ext_irq_pkg::OFS_IRQ_ENABLE:
			begin
				rd_data[8:0] = irq_enable_ff;
				rd_ok        = 1'b1;
			end
			default:
			begin
				rd_data = rd_data;
			end
		endcase
	end

	// --------------------------------------------------------------
	// gpio registers
	// --------------------------------------------------------------
	genvar gp;
	generate
		for (gp = 0; gp < ext_irq_pkg::PORT_CNT; gp++)
		begin : g_port
			localparam logic [7:0] PBASE = 8'(ext_irq_pkg::OFS_GPIO_BASE
				+ gp * ext_irq_pkg::OFS_GPIO_STRIDE);
			always_ff @(posedge ref_clk_in or negedge reset_n_in)
			begin
				if (!reset_n_in)
				begin
					gpio_regs_ff[gp].out_val <= ext_irq_pkg::GPIO_RESET;
					gpio_regs_ff[gp].dir     <= ext_irq_pkg::GPIO_RESET;
				end
				else if (wr_en)
				begin
					if (paddr_in == PBASE + ext_irq_pkg::OFS_GPIO_OUT)
					begin
						gpio_regs_ff[gp].out_val <= pwdata_in[7:0];
					end
					if (paddr_in == PBASE + ext_irq_pkg::OFS_GPIO_DIR)
					begin
						gpio_regs_ff[gp].dir <= pwdata_in[7:0];
					end
				end
			end
			assign gpio_pin_out[gp]    = gpio_regs_ff[gp].out_val;
			assign gpio_pin_oe_out[gp] = gpio_regs_ff[gp].dir;
		end
	endgenerate

	// --------------------------------------------------------------
	// control registers
	// --------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			sense_lower_ff     <= ext_irq_pkg::SENSE_RESET;
			sense_upper_ff     <= ext_irq_pkg::SENSE_RESET;
			pin_change_mask_ff <= ext_irq_pkg::MASK_RESET;
			gie_ff             <= 1'b0;
			sleep_mode_ff      <= ext_irq_pkg::SLEEP_IDLE;
			irq_enable_ff      <= ext_irq_pkg::ENABLE_RESET;
		end
		else if (wr_en)
		begin
			case (paddr_in)
				ext_irq_pkg::OFS_SENSE_LOWER: sense_lower_ff <= pwdata_in[7:0];
				ext_irq_pkg::OFS_SENSE_UPPER: sense_upper_ff <= pwdata_in[7:0];
				ext_irq_pkg::OFS_PC_MASK:     pin_change_mask_ff <= pwdata_in[7:0];
				ext_irq_pkg::OFS_CTRL:
				begin
					gie_ff        <= pwdata_in[ext_irq_pkg::CTRL_GIE_BIT];
					sleep_mode_ff <= ext_irq_pkg::sleep_mode_t'(
						pwdata_in[ext_irq_pkg::CTRL_SLEEP_LSB +: 3]);
				end
				ext_irq_pkg::OFS_IRQ_ENABLE:  irq_enable_ff <= pwdata_in[8:0];
				default:                      irq_enable_ff <= irq_enable_ff;
			endcase
		end
	end

	// --------------------------------------------------------------
	// line sampling
	// --------------------------------------------------------------
	// lines read from the pad, so self-driven outputs still trigger
	assign ext_irq_lines = {gpio_pin_in[2][7:4], gpio_pin_in[1][3:0]};

	// io clock only runs awake or in idle
	assign io_clk_run = ~sleep_active_in | (sleep_mode_ff == ext_irq_pkg::SLEEP_IDLE);

	// first cycle after reset only loads history, no false edges
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			primed_ff  <= 1'b0;
			pc_prev_ff <= 8'h00;
		end
		else
		begin
			primed_ff  <= 1'b1;
			pc_prev_ff <= pin_change_lines_in;
		end
	end

	// --------------------------------------------------------------
	// per-line sense and flags
	// --------------------------------------------------------------
	genvar gl;
	generate
		for (gl = 0; gl < ext_irq_pkg::LINE_CNT; gl++)
		begin : g_line
			logic [1:0] sense;
			logic       samp_en;
			logic       rise;
			logic       fall;

			if (gl < ext_irq_pkg::LOWER_LINES)
			begin : g_lower
				// lower lines detect in every sleep mode
				assign sense   = sense_lower_ff[2 * gl +: 2];
				assign samp_en = 1'b1;
			end
			else
			begin : g_upper
				// upper edges only while io clock runs
				assign sense   = sense_upper_ff[2 * (gl - 4) +: 2];
				assign samp_en = io_clk_run;
			end

			always_ff @(posedge ref_clk_in or negedge reset_n_in)
			begin
				if (!reset_n_in)
				begin
					ext_prev_ff[gl] <= 1'b0;
				end
				else if (samp_en | ~primed_ff)
				begin
					ext_prev_ff[gl] <= ext_irq_lines[gl];
				end
			end

			assign rise = ext_irq_lines[gl] & ~ext_prev_ff[gl];
			assign fall = ~ext_irq_lines[gl] & ext_prev_ff[gl];

			always_comb
			begin
				case (sense)
					ext_irq_pkg::SENSE_ANY:  edge_hit[gl] = rise | fall;
					ext_irq_pkg::SENSE_FALL: edge_hit[gl] = fall;
					ext_irq_pkg::SENSE_RISE: edge_hit[gl] = rise;
					default:                 edge_hit[gl] = 1'b0;
				endcase
				edge_hit[gl] = edge_hit[gl] & samp_en & primed_ff;
			end

			assign level_mode[gl] = (sense == ext_irq_pkg::SENSE_LOW);
			assign ext_clr[gl]    = (clr_wr & pwdata_in[gl]) | ext_irq_ack_in[gl];

			// level mode holds the flag clear
			always_ff @(posedge ref_clk_in or negedge reset_n_in)
			begin
				if (!reset_n_in)
				begin
					ext_irq_flags_ff[gl] <= 1'b0;
				end
				else if (level_mode[gl])
				begin
					ext_irq_flags_ff[gl] <= 1'b0;
				end
				else if (edge_hit[gl])
				begin
					ext_irq_flags_ff[gl] <= 1'b1;
				end
				else if (ext_clr[gl])
				begin
					ext_irq_flags_ff[gl] <= 1'b0;
				end
			end

			// level request follows the live pin
			assign ext_raw_req[gl] = level_mode[gl] ? ~ext_irq_lines[gl]
				: ext_irq_flags_ff[gl];
			assign wake_ev[gl] = irq_enable_ff[gl] & (level_mode[gl]
				? ~ext_irq_lines[gl] : edge_hit[gl]);
		end
	endgenerate

	// --------------------------------------------------------------
	// pin-change detection
	// --------------------------------------------------------------
	// any masked toggle, no clock gating
	assign pc_event = primed_ff & |((pin_change_lines_in ^ pc_prev_ff) & pin_change_mask_ff);
	assign pc_clr   = (clr_wr & pwdata_in[ext_irq_pkg::IRQ_PC_BIT]) | pin_change_ack_in;

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			pc_flag_ff <= 1'b0;
		end
		else if (pc_event)
		begin
			pc_flag_ff <= 1'b1;
		end
		else if (pc_clr)
		begin
			pc_flag_ff <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// request outputs
	// --------------------------------------------------------------
	// line enable and global enable gate
	assign nxt_ext_req = ext_raw_req & irq_enable_ff[7:0] & {8{gie_ff}};
	assign nxt_pc_req  = pc_flag_ff & irq_enable_ff[ext_irq_pkg::IRQ_PC_BIT] & gie_ff;

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			ext_req_ff <= 8'h00;
			pc_req_ff  <= 1'b0;
			irq_ff     <= 1'b0;
			wake_ff    <= 1'b0;
		end
		else
		begin
			ext_req_ff <= nxt_ext_req;
			pc_req_ff  <= nxt_pc_req;
			irq_ff     <= (|nxt_ext_req) | nxt_pc_req;
			wake_ff    <= sleep_active_in & ((|wake_ev)
				| (pc_event & irq_enable_ff[ext_irq_pkg::IRQ_PC_BIT]));
		end
	end

	assign ext_irq_req_out        = ext_req_ff;
	assign pin_change_request_out = pc_req_ff;
	assign irq_out                = irq_ff;
	assign wake_out               = wake_ff;
	assign prdata_out             = prdata_ff;
	assign pready_out             = pready_ff;
	assign pslverr_out            = pslverr_ff;

endmodule
